// ### include/supervisor_regs.svh
// timing, range and auto-service constants for the supervisor/watchdog block
// assumes a 125 MHz core clock; periods are counts of that clock
`ifndef SUPERVISOR_REGS_SVH
`define SUPERVISOR_REGS_SVH
// ==========================================================
// time base
`define CLK_PERIOD_NS        8
`define SCALE_NS_PER_PF      2670
`define PF_TO_CYCLES(pf)     (((pf) * `SCALE_NS_PER_PF) / `CLK_PERIOD_NS)
// ==========================================================
// default timing settings, picofarad equivalents
`define RESET_CAP_PF_RST     32'd100
`define WDOG_CAP_PF_RST      32'd1000
// ==========================================================
// range and auto-service
`define EXT_MULT             500
`define AUTO_PCT             94
`define PCT_DIV              100
`define SVC_MIN_PULSE_NS     30
`define CNT_W                48
`endif

// ### include/supervisor_pkg.sv
// types shared by the supervisor block
// no dependencies
package supervisor_pkg;
  typedef enum logic [1:0] {
    ST_UNDERVOLT,
    ST_HOLD,
    ST_RUN
  } sup_state_type;
  typedef logic [47:0] count_type;
endpackage

// ### rtl/pin_sync.sv
// two flip-flop synchroniser for a bus of asynchronous pins
// assumes one clock; reset value is constant zero
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q   <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ### rtl/supervisor_reset_watchdog.sv
// supervisor: undervoltage reset with timeout plus a watchdog timer
// assumes pins are asynchronous; timing settings are static straps
`timescale 1ns/1ps
`default_nettype none
`include "supervisor_regs.svh"

module supervisor_reset_watchdog #(
  parameter logic ACTIVE_HIGH = 1'b0,
  parameter logic OPEN_DRAIN  = 1'b1
) (
  input  wire logic                       core_clk,
  input  wire logic                       rst_n,
  input  wire logic                       below_reference,
  input  wire logic [31:0]                reset_period_pin,
  input  wire logic [31:0]                watchdog_period_pin,
  input  wire logic                       watchdog_service_input,
  input  wire logic                       watchdog_service_driven,
  input  wire logic                       watchdog_range_select,
  output logic                            reset_out_n,
  output logic                            reset_out,
  output logic                            reset_pin_o,
  output logic                            reset_pin_oe,
  output logic                            service_pin_o,
  output logic                            service_pin_oe,
  output supervisor_pkg::sup_state_type   state_out
);
  import supervisor_pkg::*;

  // ==========================================================
  // input synchronisers
  logic [3:0]    raw_in;
  logic [3:0]    sync_in;
  logic          under_s;
  logic          svc_s;
  logic          drv_s;
  logic          wds_s;
  logic          svc_prev_q;
  logic          wds_prev_q;

  assign raw_in = {below_reference, watchdog_service_input,
                   watchdog_service_driven, watchdog_range_select};

  pin_sync #(.WIDTH(4)) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .async_in (raw_in),
    .sync_out (sync_in)
  );

  assign under_s = sync_in[3];
  assign svc_s   = sync_in[2];
  assign drv_s   = sync_in[1];
  assign wds_s   = sync_in[0];

  // ==========================================================
  // period computation
  // settings are sampled after reset release, never under reset
  count_type     rst_cycles_q;
  count_type     wd_base_q;
  count_type     wd_period;
  count_type     auto_point;

  function automatic count_type pf_cycles(input logic [31:0] pf);
    logic [63:0] wide;
    wide = `PF_TO_CYCLES({32'h0000_0000, pf});
    if (wide == 64'h0)
      wide = 64'h1;
    return wide[47:0];
  endfunction

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_cycles_q <= 48'h0;
      wd_base_q    <= 48'h0;
    end
    else
    begin
      rst_cycles_q <= pf_cycles(reset_period_pin);
      wd_base_q    <= pf_cycles(watchdog_period_pin);
    end
  end

  assign wd_period = wds_s ? 48'(wd_base_q * `EXT_MULT) : wd_base_q;
  assign auto_point = 48'((wd_period * `AUTO_PCT) / `PCT_DIV);

  // ==========================================================
  // sequencer
  sup_state_type state_q;
  count_type     rst_cnt_q;
  count_type     wd_cnt_q;
  logic          svc_edge;
  logic          wds_edge;
  logic          wd_expire;
  logic          in_reset;
  logic          auto_active;
  logic          auto_pulse_q;
  logic          svc_eff;

  // internal driver wins when pin is floating in extended range
  assign auto_active = wds_s && !drv_s;
  assign svc_eff     = auto_active ? auto_pulse_q : svc_s;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      svc_prev_q <= 1'b0;
      wds_prev_q <= 1'b0;
    end
    else
    begin
      svc_prev_q <= svc_eff;
      wds_prev_q <= wds_s;
    end
  end

  assign svc_edge  = svc_eff ^ svc_prev_q;
  assign wds_edge  = wds_s ^ wds_prev_q;
  assign wd_expire = (state_q == ST_RUN) && (wd_cnt_q >= wd_period - 48'h1)
                     && !svc_edge && !wds_edge;
  assign in_reset  = (state_q != ST_RUN);

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      state_q <= ST_UNDERVOLT;
    else
    begin
      case (state_q)
        ST_UNDERVOLT:
          if (!under_s)
            state_q <= ST_HOLD;
        ST_HOLD:
          if (under_s)
            state_q <= ST_UNDERVOLT;
          else if (rst_cnt_q >= rst_cycles_q - 48'h1)
            state_q <= ST_RUN;
        ST_RUN:
          if (under_s)
            state_q <= ST_UNDERVOLT;
          else if (wd_expire)
            state_q <= ST_HOLD;
        default:
          state_q <= ST_UNDERVOLT;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      rst_cnt_q <= 48'h0;
    else if (state_q == ST_HOLD && !under_s)
      rst_cnt_q <= rst_cnt_q + 48'h1;
    else
      rst_cnt_q <= 48'h0;
  end

  // timer held at zero in reset
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      wd_cnt_q <= 48'h0;
    else if (in_reset || under_s || wd_expire)
      wd_cnt_q <= 48'h0;
    else if (svc_edge || wds_edge)
      wd_cnt_q <= 48'h0;
    else
      wd_cnt_q <= wd_cnt_q + 48'h1;
  end
  // the loop repeats through the state machine by itself

  // one-cycle high pulse at about 94 percent of the period
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      auto_pulse_q <= 1'b0;
    else
      auto_pulse_q <= auto_active && !in_reset && !auto_pulse_q
                      && (wd_cnt_q == auto_point);
  end

  // ==========================================================
  // outputs
  logic rst_level;

  assign rst_level = in_reset || under_s || wd_expire;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reset_out_n    <= 1'b0;
      reset_out      <= 1'b1;
      reset_pin_o    <= ACTIVE_HIGH;
      reset_pin_oe   <= 1'b1;
      service_pin_o  <= 1'b0;
      service_pin_oe <= 1'b0;
      state_out      <= ST_UNDERVOLT;
    end
    else
    begin
      reset_out_n    <= !rst_level;
      reset_out      <= rst_level;
      reset_pin_o    <= ACTIVE_HIGH ? rst_level : !rst_level;
      reset_pin_oe   <= OPEN_DRAIN ? ((ACTIVE_HIGH ? rst_level : !rst_level)
                        == 1'b0) : 1'b1;
      // normal range never drives the service pin
      service_pin_o  <= auto_active && auto_pulse_q;
      service_pin_oe <= auto_active;
      state_out      <= state_q;
    end
  end
endmodule
`default_nettype wire

// ### verif/sup_checker.sv
// assertion checker for the supervisor block
// assumes it is bound onto supervisor_reset_watchdog
`timescale 1ns/1ps
`default_nettype none
module sup_checker (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        below_reference,
  input wire logic [31:0] reset_period_pin,
  input wire logic [31:0] watchdog_period_pin,
  input wire logic        watchdog_service_input,
  input wire logic        watchdog_service_driven,
  input wire logic        watchdog_range_select,
  input wire logic        reset_out_n,
  input wire logic        reset_out,
  input wire logic        reset_pin_oe,
  input wire logic        service_pin_o,
  input wire logic        service_pin_oe,
  input wire supervisor_pkg::sup_state_type state_out
);
  import supervisor_pkg::*;
  // ==========================================================
  // expected periods and run-length counters
  count_type rc, wp, wb, wc, lo_q, hi_q;
  logic      svc_q, rng_q;
  assign rc = count_type'(reset_period_pin) * 48'ha6e / 48'h8;
  assign wp = count_type'(watchdog_period_pin) * 48'ha6e / 48'h8;
  assign wb = (wp == 48'h0) ? 48'h1 : wp;
  assign wc = watchdog_range_select ? wb * 48'h1f4 : wb;
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
    begin
      lo_q  <= 48'h0;
      hi_q  <= 48'h0;
      svc_q <= 1'b0;
      rng_q <= 1'b0;
    end
    else
    begin
      svc_q <= watchdog_service_input;
      rng_q <= watchdog_range_select;
      lo_q  <= reset_out_n ? 48'h0 : lo_q + 48'h1;
      // checker clears early; design sees edges two cycles later
      hi_q  <= (!reset_out_n || svc_q != watchdog_service_input
                || rng_q != watchdog_range_select) ? 48'h0 : hi_q + 48'h1;
    end
  // ==========================================================
  // assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  inv_out_a: assert property (reset_out == !reset_out_n)
    else $error("reset outputs not inverse");
  under_rise_a: assert property ($rose(below_reference) |-> ##[1:5] !reset_out_n)
    else $error("no reset after undervoltage");
  under_hold_a: assert property (below_reference[*6] |-> !reset_out_n)
    else $error("reset released while under trip");
  hold_len_a: assert property ($rose(reset_out_n) |-> lo_q >= rc - 48'h1)
    else $error("reset timeout too short");
  wd_bound_a: assert property (hi_q <= wc + 48'h8)
    else $error("watchdog failed to expire");
  wd_early_a: assert property ($fell(reset_out_n) |-> hi_q >= wc - 48'h2
    || $past(below_reference, 3) || $past(below_reference, 4))
    else $error("watchdog expired early");
  svc_oe_a: assert property ((!watchdog_range_select || watchdog_service_driven)[*4]
    |-> !service_pin_oe)
    else $error("service driver on outside extended float");
  pulse_one_a: assert property (service_pin_o |=> !service_pin_o)
    else $error("service pulse longer than a cycle");
  run_high_a: assert property ((state_out == ST_RUN)[*2] |-> $past(reset_out_n))
    else $error("reset low while running");
  drain_low_a: assert property ((!reset_out_n)[*2] |-> reset_pin_oe)
    else $error("open drain not pulling low");
  cover property ($fell(reset_out_n));
  cover property ($rose(reset_out_n));
  cover property (service_pin_oe && service_pin_o);
endmodule
bind supervisor_reset_watchdog sup_checker chk_i (.core_clk, .rst_n,
  .below_reference, .reset_period_pin, .watchdog_period_pin,
  .watchdog_service_input, .watchdog_service_driven, .watchdog_range_select,
  .reset_out_n, .reset_out, .reset_pin_oe, .service_pin_o, .service_pin_oe,
  .state_out);
`default_nettype wire

// ### verif/host_model.sv
// host model: services the watchdog pin and resolves its level
// assumes the service line has no pull resistor
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic core_clk,
  input wire logic svc_en,
  input wire logic drv,
  input wire logic [31:0] gap,
  input wire logic pin_o,
  input wire logic pin_oe,
  output logic     svc_wire
);
  int   cnt_q = 0;
  logic lvl_q = 1'b0;
  logic flt_q = 1'b0;
  // levels set and cleared, not pulsed, while driving
  always_ff @(posedge core_clk)
  begin
    cnt_q <= (svc_en && cnt_q < gap) ? cnt_q + 1 : 0;
    if (svc_en && cnt_q >= gap)
      lvl_q <= ~lvl_q;
    flt_q <= ~svc_wire;
  end
  // a floating unbuffered line never holds its last value
  assign svc_wire = drv ? lvl_q : (pin_oe ? pin_o : flt_q);
endmodule
`default_nettype wire

// ### verif/supervisor_reset_watchdog_tb.sv
// self-checking bench for the supervisor block
// assumes the host model and the bound checker compile alongside
`timescale 1ns/1ps
`default_nettype none
module supervisor_reset_watchdog_tb;
  // 1 pF at 2.67 us/pF and 8 ns per cycle
  localparam int RC = 333;
  localparam int WC = 333;
  logic core_clk = 1'b0, rst_n = 1'b0, below = 1'b0, rng = 1'b0;
  logic drv = 1'b1, svc_en = 1'b1, svc, rstn_o, rst_o, pin_o, pin_oe;
  logic [31:0] wpin = 32'h1;
  int gap = WC / 4, n, n_errors = 0, total_checks = 0;
  supervisor_reset_watchdog DUT (.core_clk(core_clk), .rst_n(rst_n),
    .below_reference(below), .reset_period_pin(32'h1),
    .watchdog_period_pin(wpin), .watchdog_service_input(svc),
    .watchdog_service_driven(drv), .watchdog_range_select(rng),
    .reset_out_n(rstn_o), .reset_out(rst_o), .reset_pin_o(),
    .reset_pin_oe(), .service_pin_o(pin_o), .service_pin_oe(pin_oe),
    .state_out());
  host_model host (.core_clk(core_clk), .svc_en(svc_en), .drv(drv),
    .gap(gap), .pin_o(pin_o), .pin_oe(pin_oe), .svc_wire(svc));
  initial forever #4 core_clk = ~core_clk;
  // ==========================================================
  // helpers
  task automatic chk(input logic s, input logic e);
    total_checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("BAD at %0t: got %b want %b", $time, s, e);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  task automatic wait_rst(input logic v, input int lim);
    n = 0;
    while (rstn_o !== v && n < lim)
    begin
      tick(1);
      n++;
    end
  endtask
  task automatic end_of_test;
    $display("errors %0d checks %0d", n_errors, total_checks);
    if (n_errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_brownout;
    below = 1'b1;
    wait_rst(1'b0, 6);
    chk(n <= 4, 1'b1);
    tick(20);
    chk(rstn_o, 1'b0);
    chk(rst_o, 1'b1);
    below = 1'b0;
    wait_rst(1'b1, RC + 40);
    chk(n >= RC && n <= RC + 8, 1'b1);
  endtask
  task automatic t_expiry;
    svc_en = 1'b0;
    wait_rst(1'b0, WC + 40);
    wait_rst(1'b1, RC + 40);
    repeat (2)
    begin
      wait_rst(1'b0, WC + 40);
      chk(n >= WC - 2 && n <= WC + 8, 1'b1);
      wait_rst(1'b1, RC + 40);
      chk(n >= RC - 1 && n <= RC + 8, 1'b1);
    end
    svc_en = 1'b1;
  endtask
  task automatic t_service;
    wait_rst(1'b0, 3 * WC);
    chk(rstn_o, 1'b1);
    svc_en = 1'b0;
    tick(WC / 2);
    rng = 1'b1;
    tick(WC / 2);
    rng = 1'b0;
    tick(WC / 2);
    chk(rstn_o, 1'b1);
    svc_en = 1'b1;
  endtask
  task automatic t_extended;
    int p = 0;
    logic up = 1'b1;
    rst_n = 1'b0;
    wpin = 32'h0;
    rng = 1'b1;
    drv = 1'b0;
    tick(2);
    rst_n = 1'b1;
    wait_rst(1'b1, RC + 40);
    repeat (1500)
    begin
      tick(1);
      p += (pin_oe && pin_o) ? 1 : 0;
      up &= rstn_o;
    end
    chk(p >= 2, 1'b1);
    chk(up, 1'b1);
    drv = 1'b1;
    tick(gap + 3);
    svc_en = 1'b0;
    wait_rst(1'b0, 600);
    chk(n >= 400 && n <= 510, 1'b1);
  endtask
  initial
  begin
    tick(8);
    rst_n = 1'b1;
    wait_rst(1'b1, RC + 40);
    chk(n >= RC && n <= RC + 8, 1'b1);
    t_brownout();
    t_expiry();
    t_service();
    t_extended();
    end_of_test();
  end
  initial
  begin
    #(8 * 20000);
    n_errors++;
    end_of_test();
  end
endmodule
`default_nettype wire
